// ### sim/occ_channel_props.sv
// Port-level checks of the compare channel
`include "occ_defines.svh"
module occ_channel_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`OCC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Time bases, status, pin
  input wire logic [15:0] first_timer,
  input wire logic [15:0] second_timer,
  input wire logic cpu_idle,
  input wire logic fault_n,
  input wire logic compare_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ctl_q, ca_q, ps_q;
  wire [2:0] m = ctl_q[2:0];
  wire [15:0] sel = ctl_q[`OCC_BIT_TSEL] ? second_timer : first_timer;
  wire hlt = ctl_q[`OCC_BIT_IDLE] && cpu_idle;
  // First cycle of equality only; a dwelling count matches once
  wire eq = sel == ca_q && ps_q != ca_q && !hlt && !reg_wr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 16'h0;
      ca_q <= 16'h0;
      ps_q <= 16'h0;
    end else begin
      ps_q <= sel;
      if (reg_wr && reg_addr == `OCC_OFS_CTRL) ctl_q <= reg_wdata;
      if (reg_wr && reg_addr == `OCC_OFS_CMP_A) ca_q <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ctrl_bits_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == `OCC_OFS_CTRL |->
    reg_rdata[15:14] == 2'h0 && reg_rdata[12:5] == 8'h0) else $error("ctrl pad bits set");
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > `OCC_OFS_INT_MASK |->
    reg_rdata == 16'h0) else $error("unmapped read not zero");
  off_pin_low_a: assert property ((m == 3'h0) [*3] |-> !compare_output_pin) else $error("pin high when off");
  hi_match_a: assert property (m == 3'h1 && eq ##1 !reg_wr |-> ##1 compare_output_pin) else $error("no set");
  lo_match_a: assert property (m == 3'h2 && eq ##1 !reg_wr |-> ##1 !compare_output_pin) else $error("no clr");
  toggle_match_a: assert property (m == 3'h3 && eq ##1 !reg_wr |->
    ##1 compare_output_pin != $past(compare_output_pin)) else $error("no toggle");
  pulse_rise_a: assert property (m == 3'h5 && eq ##1 !reg_wr |-> ##1 compare_output_pin) else $error("no rise");
  idle_halt_a: assert property ((hlt && !reg_wr) [*3] |-> $stable(compare_output_pin)) else $error("moved");
  fault_low_a: assert property ((m == 3'h7 && !fault_n && !reg_wr) [*3] |->
    !compare_output_pin) else $error("pin high in fault");
endmodule
bind occ_channel occ_channel_props chk_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .first_timer, .second_timer, .cpu_idle, .fault_n, .compare_output_pin);

// ### sim/occ_channel_test.sv
// Self-checking bench for the compare channel
`include "occ_defines.svh"
module occ_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`OCC_ADDR_W-1:0] reg_addr = '0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] first_timer = 16'h0;
  logic [15:0] second_timer = 16'h0;
  logic cpu_idle = 1'b0;
  logic fault_n = 1'b1;
  wire [15:0] reg_rdata;
  wire compare_output_pin, irq;
  wire [7:0] rises;
  int errors = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  // Short periods so pulse trains repeat quickly: 64 and 128 cycles
  always @(posedge clk) begin
    first_timer <= first_timer == 16'h3f ? 16'h0 : first_timer + 16'h1;
    second_timer <= second_timer == 16'h7f ? 16'h0 : second_timer + 16'h1;
  end
  occ_channel dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .first_timer,
    .second_timer, .cpu_idle, .fault_n, .compare_output_pin, .irq);
  occ_load load_u (.clk, .rst, .pin(compare_output_pin), .rises);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wt(input logic [15:0] v);
    int i;
    for (i = 0; i < 200 && first_timer !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (i >= 200) begin
      errors++;
      results();
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Settle 70 cycles, then count edges over two first-timer periods
  task automatic win(input logic [15:0] c, output logic [7:0] all, output logic [7:0] tail);
    logic [7:0] r0;
    r0 = rises;
    wr(`OCC_OFS_CTRL, c);
    repeat (70) @(posedge clk);
    #1 tail = rises;
    repeat (128) @(posedge clk);
    #1 all = rises - r0;
    tail = rises - tail;
  endtask
  task automatic t_regs;
    rd(`OCC_OFS_CTRL, `OCC_CTRL_RST);
    rd(`OCC_OFS_INT_MASK, 16'h0);
    wr(`OCC_OFS_CTRL, 16'hffff);
    rd(`OCC_OFS_CTRL, `OCC_CTRL_WMASK);
    rd(4'h7, 16'h0);
    wr(`OCC_OFS_CTRL, 16'h0);
  endtask
  task automatic t_single;
    logic [15:0] m;
    wr(`OCC_OFS_CMP_A, 16'h20);
    for (m = 16'h1; m < 16'h4; m++) begin
      wr(`OCC_OFS_CTRL, m);
      @(posedge clk);
      #1 chk(compare_output_pin, m == 16'h2);
      wt(16'h20);
      chk(compare_output_pin, m != 16'h2);
    end
    wt(16'h20);
    chk(compare_output_pin, 16'h0);
  endtask
  task automatic t_irq;
    wr(`OCC_OFS_CTRL, 16'h0);
    rd(`OCC_OFS_INT_STAT, 16'h1);
    chk(irq, 16'h0);
    wr(`OCC_OFS_INT_MASK, 16'h1);
    #1 chk(irq, 16'h1);
    wr(`OCC_OFS_INT_STAT, 16'h1);
    #1 chk(irq, 16'h0);
  endtask
  task automatic t_pulses;
    logic [7:0] a, t;
    wr(`OCC_OFS_CMP_A, 16'h10);
    wr(`OCC_OFS_CMP_B, 16'h20);
    rd(`OCC_OFS_CMP_A, 16'h10);
    rd(`OCC_OFS_CMP_B, 16'h20);
    win(16'h0, a, t);
    chk(a, 8'h0);
    win(16'h4, a, t);
    chk(a, 8'h1);
    chk(t, 8'h0);
    win(16'h5, a, t);
    chk(t, 8'h2);
    win(16'hd, a, t);
    chk(t, 8'h1);
    @(posedge clk) cpu_idle <= 1'b1;
    win(16'h5, a, t);
    chk(t, 8'h2);
    win(16'h2005, a, t);
    chk(t, 8'h0);
    @(posedge clk) cpu_idle <= 1'b0;
  endtask
  task automatic t_fault;
    logic [7:0] a, t;
    @(posedge clk) fault_n <= 1'b0;
    win(16'h6, a, t);
    chk(t, 8'h2);
    rd(`OCC_OFS_CTRL, 16'h6);
    win(16'h7, a, t);
    chk(t, 8'h0);
    rd(`OCC_OFS_CTRL, 16'h17);
    rd(`OCC_OFS_INT_STAT, 16'h3);
    @(posedge clk) fault_n <= 1'b1;
    a = rises;
    repeat (128) @(posedge clk);
    #1 chk(rises - a, 8'h0);
    win(16'h7, a, t);
    chk(t, 8'h2);
    rd(`OCC_OFS_CTRL, 16'h7);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_irq();
    t_pulses();
    t_fault();
    results();
  end
endmodule

// ### sim/occ_load.sv
// Load model on the compare pin: counts rising edges
module occ_load (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and edge count
  input wire logic pin,
  output logic [7:0] rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
      rises <= 8'h0;
    end else begin
      prev <= pin;
      rises <= rises + 8'(pin && !prev);
    end
  end
endmodule

// ### src/occ_channel.sv
// Output compare channel: control register, modes, fault, interrupts
`include "occ_defines.svh"
module occ_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`OCC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Time bases
  input wire logic [15:0] first_timer,
  input wire logic [15:0] second_timer,
  // System status
  input wire logic cpu_idle,
  input wire logic fault_n,
  // Outputs
  output logic compare_output_pin,
  output logic irq
);
  import occ_pkg::*;

  typedef struct packed {
    logic idle_halt_select;
    logic pwm_fault_flag;
    logic timebase_select;
    occ_mode_t mode;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [`OCC_INT_W-1:0] int_stat;
    logic [`OCC_INT_W-1:0] int_mask;
    occ_state_t seq;
    logic pin;
    logic [15:0] rdata;
  } occ_st_t;

  occ_st_t st_q, st_d;
  logic run;
  logic match_a;
  logic match_b;
  logic wrap;
  logic [15:0] ctrl_view;

  // Control register as software sees it
  function automatic logic [15:0] ctrl_word(input occ_st_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[`OCC_BIT_IDLE] = s.idle_halt_select;
    w[`OCC_BIT_FLT] = s.pwm_fault_flag;
    w[`OCC_BIT_TSEL] = s.timebase_select;
    w[`OCC_MODE_HI:`OCC_MODE_LO] = s.mode;
    return w;
  endfunction

  // Write-one-to-clear with hardware set winning
  function automatic logic [`OCC_INT_W-1:0] w1c(input logic [`OCC_INT_W-1:0] cur,
                                               input logic [`OCC_INT_W-1:0] clr,
                                               input logic [`OCC_INT_W-1:0] set);
    return (cur & ~clr) | set;
  endfunction

  assign ctrl_view = ctrl_word(st_q);
  // Halted while disabled, or in idle with halt selected
  assign run = (st_q.mode != OCC_OFF) && !(st_q.idle_halt_select && cpu_idle);

  occ_match u_match (
    .clk(clk),
    .rst(rst),
    .first_timer(first_timer),
    .second_timer(second_timer),
    .timebase_select(st_q.timebase_select),
    .cmp_a(st_q.cmp_a),
    .cmp_b(st_q.cmp_b),
    .run(run),
    .match_a(match_a),
    .match_b(match_b),
    .wrap(wrap)
  );

  always_comb begin
    logic mode_wr;
    logic [`OCC_INT_W-1:0] clr;
    logic [`OCC_INT_W-1:0] set;
    occ_mode_t new_mode;
    mode_wr = 1'b0;
    clr = '0;
    set = '0;
    new_mode = st_q.mode;
    st_d = st_q;
    st_d.rdata = 16'h0000;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == `OCC_OFS_CTRL) begin
        // Flag bit is read-only; only writable bits are taken
        st_d.idle_halt_select = reg_wdata[`OCC_BIT_IDLE];
        st_d.timebase_select = reg_wdata[`OCC_BIT_TSEL];
        new_mode = occ_mode_t'(reg_wdata[`OCC_MODE_HI:`OCC_MODE_LO]);
        mode_wr = 1'b1;
      end else if (reg_addr == `OCC_OFS_CMP_A) begin
        st_d.cmp_a = reg_wdata;
      end else if (reg_addr == `OCC_OFS_CMP_B) begin
        st_d.cmp_b = reg_wdata;
      end else if (reg_addr == `OCC_OFS_INT_STAT) begin
        clr = reg_wdata[`OCC_INT_W-1:0];
      end else if (reg_addr == `OCC_OFS_INT_MASK) begin
        st_d.int_mask = reg_wdata[`OCC_INT_W-1:0];
      end
    end

    // Pin and sequence behaviour per mode
    case (st_q.mode)
      OCC_OFF: begin
        st_d.seq = OCC_ST_IDLE;
      end
      OCC_SET_HI: begin
        if (match_a) begin
          st_d.pin = 1'b1;
        end
      end
      OCC_SET_LO: begin
        if (match_a) begin
          st_d.pin = 1'b0;
        end
      end
      OCC_TOGGLE: begin
        if (match_a) begin
          st_d.pin = !st_q.pin;
        end
      end
      OCC_ONE_PULSE, OCC_PULSES: begin
        // A raises the pin, B ends the pulse
        case (st_q.seq)
          OCC_ST_WAIT_A: begin
            if (match_a) begin
              st_d.pin = 1'b1;
              st_d.seq = OCC_ST_WAIT_B;
            end
          end
          OCC_ST_WAIT_B: begin
            if (match_b) begin
              st_d.pin = 1'b0;
              st_d.seq = (st_q.mode == OCC_ONE_PULSE) ? OCC_ST_DONE : OCC_ST_WAIT_A;
            end
          end
          OCC_ST_DONE: begin
            st_d.pin = 1'b0;
          end
          default: begin
            st_d.seq = OCC_ST_WAIT_A;
          end
        endcase
      end
      OCC_PWM, OCC_PWM_FLT: begin
        // Period starts on wrap; duty ends on match with A
        // Halted channel ignores the fault too, so the pin stays frozen in idle
        if (st_q.mode == OCC_PWM_FLT && !fault_n && run) begin
          st_d.pwm_fault_flag = 1'b1;
          set[`OCC_INT_FAULT] = 1'b1;
        end
        if (st_q.pwm_fault_flag && st_q.mode == OCC_PWM_FLT) begin
          st_d.pin = 1'b0;
        end else if (st_q.mode == OCC_PWM_FLT && !fault_n && run) begin
          st_d.pin = 1'b0;
        end else if (match_a) begin
          st_d.pin = 1'b0;
        end else if (wrap && run) begin
          st_d.pin = (st_q.cmp_a != 16'h0000);
        end
      end
      default: begin
        st_d.seq = OCC_ST_IDLE;
      end
    endcase

    // Match events feed the interrupt status
    if (match_a || match_b) begin
      set[`OCC_INT_MATCH] = 1'b1;
    end
    st_d.int_stat = w1c(st_q.int_stat, clr, set);

    // Mode rewrite clears the fault and initialises the pin; the pin keeps its value when the same toggle or PWM mode is written again
    if (mode_wr) begin
      st_d.mode = new_mode;
      // A fault present in the same cycle wins over the clear when OCC_PWM_FLT is written
      st_d.pwm_fault_flag = st_d.pwm_fault_flag && (new_mode == OCC_PWM_FLT) && !fault_n;
      st_d.seq = OCC_ST_WAIT_A;
      if (new_mode == OCC_SET_LO) begin
        st_d.pin = 1'b1;
      end else if (new_mode == OCC_TOGGLE && st_q.mode == OCC_TOGGLE) begin
        st_d.pin = st_d.pin;
      end else if (new_mode == OCC_PWM || new_mode == OCC_PWM_FLT) begin
        st_d.pin = (st_q.mode == new_mode) ? st_d.pin : 1'b0;
      end else begin
        st_d.pin = 1'b0;
      end
    end

    // Reads: data stand one cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == `OCC_OFS_CTRL) begin
        st_d.rdata = ctrl_view;
      end else if (reg_addr == `OCC_OFS_CMP_A) begin
        st_d.rdata = st_q.cmp_a;
      end else if (reg_addr == `OCC_OFS_CMP_B) begin
        st_d.rdata = st_q.cmp_b;
      end else if (reg_addr == `OCC_OFS_INT_STAT) begin
        st_d.rdata = {{(16-`OCC_INT_W){1'b0}}, st_q.int_stat};
      end else if (reg_addr == `OCC_OFS_INT_MASK) begin
        st_d.rdata = {{(16-`OCC_INT_W){1'b0}}, st_q.int_mask};
      end else begin
        st_d.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign compare_output_pin = st_q.pin;
  assign irq = |(st_q.int_stat & st_q.int_mask);
endmodule

// ### src/occ_defines.svh
// Register offsets, field positions, reset values and constants of the compare channel
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH
`define OCC_ADDR_W 4
`define OCC_OFS_CTRL 4'h0
`define OCC_OFS_CMP_A 4'h1
`define OCC_OFS_CMP_B 4'h2
`define OCC_OFS_INT_STAT 4'h3
`define OCC_OFS_INT_MASK 4'h4
`define OCC_BIT_IDLE 13
`define OCC_BIT_FLT 4
`define OCC_BIT_TSEL 3
`define OCC_MODE_HI 2
`define OCC_MODE_LO 0
`define OCC_CTRL_WMASK 16'h200f
`define OCC_CTRL_RST 16'h0000
`define OCC_CMP_RST 16'h0000
`define OCC_INT_MATCH 0
`define OCC_INT_FAULT 1
`define OCC_INT_W 2
`endif

// ### src/occ_match.sv
// Time base selection and compare-match pulse generation
`include "occ_defines.svh"
module occ_match (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Time bases and compare values
  input wire logic [15:0] first_timer,
  input wire logic [15:0] second_timer,
  input wire logic timebase_select,
  input wire logic [15:0] cmp_a,
  input wire logic [15:0] cmp_b,
  input wire logic run,
  // Match pulses and period wrap
  output logic match_a,
  output logic match_b,
  output logic wrap
);
  import occ_pkg::*;
  typedef struct packed {
    logic [15:0] prev;
    logic hit_a;
    logic hit_b;
  } occ_match_st_t;
  occ_match_st_t st_q, st_d;
  logic [15:0] count;

  // Selected timer count
  assign count = timebase_select ? second_timer : first_timer;

  // Pulse on the first cycle of equality, then on every other cycle while the timer dwells on the value
  always_comb begin
    st_d = st_q;
    st_d.prev = count;
    st_d.hit_a = run && (count == cmp_a) && (count != st_q.prev || !st_q.hit_a);
    st_d.hit_b = run && (count == cmp_b) && (count != st_q.prev || !st_q.hit_b);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign match_a = st_q.hit_a;
  assign match_b = st_q.hit_b;
  // Wrap: count fell below the previous value
  assign wrap = run && (count < st_q.prev);
endmodule

// ### src/occ_pkg.sv
// Types shared by the compare channel files
package occ_pkg;
  typedef enum logic [2:0] {
    OCC_OFF = 3'h0,
    OCC_SET_HI = 3'h1,
    OCC_SET_LO = 3'h2,
    OCC_TOGGLE = 3'h3,
    OCC_ONE_PULSE = 3'h4,
    OCC_PULSES = 3'h5,
    OCC_PWM = 3'h6,
    OCC_PWM_FLT = 3'h7
  } occ_mode_t;
  typedef enum logic [1:0] {
    OCC_ST_IDLE = 2'b00,
    OCC_ST_WAIT_A = 2'b01,
    OCC_ST_WAIT_B = 2'b11,
    OCC_ST_DONE = 2'b10
  } occ_state_t;
endpackage
